// ==== sar_adc_control.sv ====
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`include "sar_adc_control_params.svh"
module sar_adc_control (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire sar_adc_control_pkg::wb_req_type wb_req,
   output sar_adc_control_pkg::wb_rsp_type wb_rsp,
   input wire logic osc_tick,
   input wire logic stop_mode,
   input wire logic cmp_high,
   output sar_adc_control_pkg::analog_ctrl_type analog,
   output logic irq_request
);
   import sar_adc_control_pkg::*;

   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic irq_enable_reg;
   logic continuous_reg;
   logic [4:0] channel_reg;
   logic done_flag_reg;
   logic [7:0] result_reg;
   logic [2:0] prescale_reg;
   logic input_sel_reg;
   logic irq_reg;
   logic settle_reg;
   logic run_pending_reg;
   logic stop_prev_reg;
   logic power_down_reg;
   logic rd_status_q;

   logic access;
   logic wr_status;
   logic wr_clock;
   logic rd_result;
   logic new_on;
   logic stop_exit;
   logic seq_start;
   logic seq_abort;
   logic commit;
   logic src_tick;
   logic adc_tick;
   logic seq_busy;
   logic seq_done;
   logic [7:0] seq_result;
   logic [7:0] dac_code;
   logic sample_enable;

   // Bus decode: one access per ack, answered one cycle after the strobe
   assign access = wb_req.cyc && wb_req.stb && !ack_reg;
   assign wr_status = access && wb_req.we && wb_req.sel[0]
                      && wb_req.adr == `OFS_STATUS_CONTROL;
   assign wr_clock = access && wb_req.we && wb_req.sel[0]
                     && wb_req.adr == `OFS_CLOCK_CONFIG;
   assign rd_result = access && !wb_req.we && wb_req.adr == `OFS_RESULT;
   assign new_on = wb_req.dat[`CHANNEL_MSB:0] != `CH_POWER_OFF;
   assign stop_exit = stop_prev_reg && !stop_mode;

   // Conversion start and abort
   assign seq_start = (wr_status && new_on && !stop_mode)
      || (seq_done && (settle_reg || continuous_reg) && !wr_status
          && !stop_mode)
      || (stop_exit && (continuous_reg || run_pending_reg)
          && channel_reg != `CH_POWER_OFF);
   assign seq_abort = wr_status || stop_mode;
   assign commit = seq_done && !settle_reg && !wr_status;

   // Prescaler source: bus clock runs every cycle
   assign src_tick = input_sel_reg ? 1'b1 : osc_tick;

   adc_clock_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .src_tick(src_tick),
      .prescale(prescale_reg),
      .adc_tick(adc_tick)
   );

   sar_sequencer u_sequencer (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(seq_start),
      .abort(seq_abort),
      .adc_tick(adc_tick),
      .cmp_high(cmp_high),
      .busy(seq_busy),
      .done(seq_done),
      .result(seq_result),
      .dac_code(dac_code),
      .sample_enable(sample_enable)
   );

   // Read data
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (wb_req.adr)
         `OFS_STATUS_CONTROL: begin
            rdata_next[`BIT_DONE_FLAG] = done_flag_reg
                                         && !irq_enable_reg;
            rdata_next[`BIT_IRQ_ENABLE] = irq_enable_reg;
            rdata_next[`BIT_CONTINUOUS] = continuous_reg;
            rdata_next[`CHANNEL_MSB:0] = channel_reg;
         end
         `OFS_RESULT: rdata_next[7:0] = result_reg;
         `OFS_CLOCK_CONFIG: begin
            rdata_next[`PRESCALE_MSB:`PRESCALE_LSB] = prescale_reg;
            rdata_next[`BIT_INPUT_SELECT] = input_sel_reg;
         end
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= access;
         if (access && !wb_req.we) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign wb_rsp.ack = ack_reg;
   assign wb_rsp.dat = rdata_reg;

   // Status and control fields; the done flag position is not writable
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_enable_reg <= 1'(`RST_STATUS_CONTROL
                              >> `BIT_IRQ_ENABLE);
         continuous_reg <= 1'b0;
         channel_reg <= `CH_POWER_OFF;
      end else if (wr_status) begin
         irq_enable_reg <= wb_req.dat[`BIT_IRQ_ENABLE];
         continuous_reg <= wb_req.dat[`BIT_CONTINUOUS];
         channel_reg <= wb_req.dat[`CHANNEL_MSB:0];
      end
   end

   // Clock configuration
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prescale_reg <= 3'(`RST_CLOCK_CONFIG >> `PRESCALE_LSB);
         input_sel_reg <= 1'b0;
      end else if (wr_clock) begin
         prescale_reg <= wb_req.dat[`PRESCALE_MSB:`PRESCALE_LSB];
         input_sel_reg <= wb_req.dat[`BIT_INPUT_SELECT];
      end
   end

   // Result register, overwritten at every kept conversion
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         result_reg <= 8'h00;
      end else if (commit) begin
         result_reg <= seq_result;
      end
   end

   // Done flag: set beats the clearing read
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         done_flag_reg <= 1'b0;
      end else if (commit && !irq_enable_reg) begin
         done_flag_reg <= 1'b1;
      end else if (rd_result) begin
         done_flag_reg <= 1'b0;
      end
   end

   // Interrupt request, usable as a wake source in wait mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_reg <= 1'b0;
      end else if (commit && irq_enable_reg) begin
         irq_reg <= 1'b1;
      end else if (rd_result || wr_status) begin
         irq_reg <= 1'b0;
      end
   end

   assign irq_request = irq_reg;

   // Settling conversion after power-off or stop
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         settle_reg <= 1'b0;
      end else if ((wr_status && new_on && channel_reg == `CH_POWER_OFF)
                   || stop_exit) begin
         settle_reg <= 1'b1;
      end else if (seq_done && !wr_status) begin
         settle_reg <= 1'b0;
      end
   end

   // A single conversion owed to software
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         run_pending_reg <= 1'b0;
      end else if (wr_status) begin
         run_pending_reg <= new_on;
      end else if (commit) begin
         run_pending_reg <= 1'b0;
      end
   end

   // Stop edge and power-down output
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stop_prev_reg <= 1'b0;
         power_down_reg <= 1'b1;
      end else begin
         stop_prev_reg <= stop_mode;
         power_down_reg <= stop_mode || (wr_status ? !new_on
            : channel_reg == `CH_POWER_OFF);
      end
   end

   assign analog.mux_select = channel_reg;
   assign analog.power_down = power_down_reg;
   assign analog.sample_enable = sample_enable;
   assign analog.dac_code = dac_code;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_status_q <= 1'b0;
      end else begin
         rd_status_q <= access && !wb_req.we
                        && wb_req.adr == `OFS_STATUS_CONTROL;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   property p_irq_set;
      commit && irq_enable_reg |=> irq_request;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt not raised after conversion");

   property p_flag_hidden;
      rd_status_q && irq_enable_reg |-> !wb_rsp.dat[`BIT_DONE_FLAG];
   endproperty
   a_flag_hidden: assert property (p_flag_hidden)
      else $error("done flag visible with interrupts enabled");

   property p_flag_set;
      commit && !irq_enable_reg |=> done_flag_reg && !irq_request;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("done flag not set after conversion");

   property p_irq_clear;
      (rd_result || wr_status) && !commit |=> !irq_request;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt not withdrawn");

   property p_continuous;
      seq_done && continuous_reg && !wr_status && !stop_mode |=> seq_busy;
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("continuous mode did not restart");

   property p_power_off;
      channel_reg == `CH_POWER_OFF |-> !seq_busy && power_down_reg;
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("converter active with power-off code");

   property p_stop_abort;
      stop_mode |=> !seq_busy ##1 !commit;
   endproperty
   a_stop_abort: assert property (p_stop_abort)
      else $error("conversion ran during stop mode");

   property p_result_source;
      $changed(result_reg) |-> $past(commit);
   endproperty
   a_result_source: assert property (p_result_source)
      else $error("result changed without a completed conversion");

   property p_write_restart;
      wr_status && new_on && !stop_mode |=> seq_busy && !seq_done;
   endproperty
   a_write_restart: assert property (p_write_restart)
      else $error("status write did not start a conversion");

   property p_single_stop;
      seq_done && !continuous_reg && !settle_reg && !wr_status |=> !seq_busy;
   endproperty
   a_single_stop: assert property (p_single_stop)
      else $error("single mode started a second conversion");

   property p_flag_clear;
      rd_result && !commit |=> !done_flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("done flag not cleared by result read");

   property p_channel_follow;
      wr_status |=> analog.mux_select == $past(wb_req.dat[`CHANNEL_MSB:0]);
   endproperty
   a_channel_follow: assert property (p_channel_follow)
      else $error("channel select did not follow status write");

   cover_irq: cover property (commit && irq_enable_reg);
   cover_two_results: cover property (commit ##[1:600] commit);
   cover_settle: cover property (seq_done && settle_reg);
endmodule

// ==== sar_adc_control_params.svh ====
`ifndef SAR_ADC_CONTROL_PARAMS_SVH
`define SAR_ADC_CONTROL_PARAMS_SVH

`define OFS_STATUS_CONTROL 8'h00
`define OFS_RESULT 8'h04
`define OFS_CLOCK_CONFIG 8'h08

`define BIT_DONE_FLAG 7
`define BIT_IRQ_ENABLE 6
`define BIT_CONTINUOUS 5
`define CHANNEL_MSB 4
`define PRESCALE_MSB 7
`define PRESCALE_LSB 5
`define BIT_INPUT_SELECT 4

`define RST_STATUS_CONTROL 8'h1f
`define RST_CLOCK_CONFIG 8'h00

`define CH_HIGH_REF 5'h1d
`define CH_LOW_REF 5'h1e
`define CH_POWER_OFF 5'h1f

`define SAMPLE_TICKS 4'h8
// First tick after a start is partial and only aligns to the ADC clock
`define SAMPLE_ALIGN 4'hf
`define CONV_TICKS 5'h11

`endif

// ==== sar_adc_control_pkg.sv ====
package sar_adc_control_pkg;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_type;

   typedef struct packed {
      logic [4:0] mux_select;
      logic power_down;
      logic sample_enable;
      logic [7:0] dac_code;
   } analog_ctrl_type;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_SAMPLE = 2'b01,
      SEQ_CONVERT = 2'b11
   } seq_state_type;

   // Last count value of the prescaler for a divide code
   function automatic logic [3:0] prescale_last(input logic [2:0] code);
      logic [3:0] last;
      last = 4'hf;
      unique case (code)
         3'h0: last = 4'h0;
         3'h1: last = 4'h1;
         3'h2: last = 4'h3;
         3'h3: last = 4'h7;
         default: last = 4'hf;
      endcase
      return last;
   endfunction

endpackage

// ==== adc_clock_prescaler.sv ====
`timescale 1ns/10ps
module adc_clock_prescaler (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic src_tick,
   input wire logic [2:0] prescale,
   output logic adc_tick
);
   import sar_adc_control_pkg::*;

   logic [3:0] count_reg;
   logic tick_reg;
   logic wrap;

   assign wrap = count_reg >= prescale_last(prescale);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 4'h0;
      end else if (src_tick) begin
         if (wrap) begin
            count_reg <= 4'h0;
         end else begin
            count_reg <= count_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= src_tick && wrap;
      end
   end

   assign adc_tick = tick_reg;

   property p_div_one;
      @(posedge clk_sys) disable iff (!arst_n)
      (src_tick && prescale == 3'h0) |=> adc_tick;
   endproperty
   a_div_one: assert property (p_div_one)
      else $error("prescaler missed divide-by-one tick");

   property p_div_two;
      @(posedge clk_sys) disable iff (!arst_n)
      (adc_tick && prescale == 3'h1 && $past(prescale) == 3'h1
         && $past(src_tick)) |-> !$past(adc_tick);
   endproperty
   a_div_two: assert property (p_div_two)
      else $error("prescaler ticked twice in a row at divide-by-two");
endmodule

// ==== sar_sequencer.sv ====
`timescale 1ns/10ps
`include "sar_adc_control_params.svh"
module sar_sequencer (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic start,
   input wire logic abort,
   input wire logic adc_tick,
   input wire logic cmp_high,
   output logic busy,
   output logic done,
   output logic [7:0] result,
   output logic [7:0] dac_code,
   output logic sample_enable
);
   import sar_adc_control_pkg::*;

   seq_state_type state_reg;
   logic [3:0] count_reg;
   logic [7:0] code_reg;
   logic [7:0] mask_reg;
   logic [7:0] result_reg;
   logic done_reg;
   logic [7:0] keep;
   logic last_bit;
   logic [4:0] ticks_reg;
   logic sample_reg;

   assign keep = cmp_high ? code_reg : (code_reg & ~mask_reg);
   assign last_bit = adc_tick && state_reg == SEQ_CONVERT && mask_reg[0];

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SEQ_IDLE;
         count_reg <= 4'h0;
         sample_reg <= 1'b0;
      end else if (start) begin
         state_reg <= SEQ_SAMPLE;
         count_reg <= `SAMPLE_ALIGN;
         sample_reg <= 1'b1;
      end else if (abort) begin
         state_reg <= SEQ_IDLE;
         sample_reg <= 1'b0;
      end else if (adc_tick) begin
         unique case (state_reg)
            SEQ_IDLE: state_reg <= SEQ_IDLE;
            SEQ_SAMPLE: begin
               if (count_reg == `SAMPLE_TICKS - 4'h1) begin
                  state_reg <= SEQ_CONVERT;
                  sample_reg <= 1'b0;
               end
               count_reg <= count_reg + 4'h1;
            end
            SEQ_CONVERT: begin
               if (mask_reg[0]) begin
                  state_reg <= SEQ_IDLE;
               end
            end
            default: begin
               state_reg <= SEQ_IDLE;
               sample_reg <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         code_reg <= 8'h00;
         mask_reg <= 8'h00;
      end else if (start) begin
         code_reg <= 8'h00;
         mask_reg <= 8'h00;
      end else if (adc_tick && state_reg == SEQ_SAMPLE
                   && count_reg == `SAMPLE_TICKS - 4'h1) begin
         code_reg <= 8'h80;
         mask_reg <= 8'h80;
      end else if (adc_tick && state_reg == SEQ_CONVERT && !mask_reg[0]) begin
         code_reg <= keep | (mask_reg >> 1);
         mask_reg <= mask_reg >> 1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         result_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         done_reg <= last_bit && !start && !abort;
         if (last_bit && !start && !abort) begin
            result_reg <= keep;
         end
      end
   end

   assign busy = state_reg != SEQ_IDLE;
   assign done = done_reg;
   assign result = result_reg;
   assign dac_code = code_reg;
   assign sample_enable = sample_reg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ticks_reg <= 5'h00;
      end else if (start) begin
         ticks_reg <= 5'h00;
      end else if (adc_tick && busy) begin
         ticks_reg <= ticks_reg + 5'h01;
      end
   end

   property p_conv_length;
      @(posedge clk_sys) disable iff (!arst_n)
      done |-> ticks_reg == `CONV_TICKS;
   endproperty
   a_conv_length: assert property (p_conv_length)
      else $error("conversion did not take seventeen ADC ticks");

   cover_done: cover property (@(posedge clk_sys) disable iff (!arst_n)
      done);
endmodule

// ==== adc_analog_model.sv ====
`timescale 1ns/10ps
module adc_analog_model (
   input wire logic clk_sys,
   input wire sar_adc_control_pkg::analog_ctrl_type analog,
   input wire logic [7:0] offset,
   output logic cmp_high
);
   import sar_adc_control_pkg::*;
   logic [7:0] held = 8'h00;
   logic toggle = 1'b0;
   function automatic logic [7:0] level(input logic [4:0] ch,
                                         input logic [7:0] ofs);
      if (ch < 5'h08) begin
         return 8'h13 + {ch[2:0], 5'h00} + ofs;
      end
      if (ch == 5'h1d) begin
         return 8'hff;
      end
      if (ch == 5'h1e) begin
         return 8'h00;
      end
      return 8'h5a;
   endfunction
   // Sample held while sampling phase runs
   always_ff @(posedge clk_sys) begin
      toggle <= ~toggle;
      if (analog.sample_enable) begin
         held <= level(analog.mux_select, offset);
      end
   end
   // Powered off comparator gives no stable answer
   assign cmp_high = analog.power_down ? toggle
                     : (held >= analog.dac_code);
endmodule

// ==== sar_adc_control_tb.sv ====
`timescale 1ns/10ps
module sar_adc_control_tb;
   import sar_adc_control_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n;
   wb_req_type wb_req;
   wb_rsp_type wb_rsp;
   logic osc_tick = 1'b0;
   logic stop_mode;
   logic cmp_high;
   analog_ctrl_type analog;
   logic irq_request;
   logic [7:0] offset;
   logic [1:0] osc_cnt = 2'h0;
   logic [31:0] rdat;
   int failures;
   int checks;

   sar_adc_control DUT (.clk_sys(clk_sys), .arst_n(arst_n), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .osc_tick(osc_tick), .stop_mode(stop_mode),
      .cmp_high(cmp_high), .analog(analog), .irq_request(irq_request));
   adc_analog_model analog_side (.clk_sys(clk_sys), .analog(analog),
      .offset(offset), .cmp_high(cmp_high));

   always #20 clk_sys = ~clk_sys;

   // Oscillator tick every fourth system cycle
   always @(posedge clk_sys) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_tick <= (osc_cnt == 2'h3);
   end

   task automatic conclude();
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] expv(input logic [4:0] ch,
                                        input logic [7:0] ofs);
      if (ch == 5'h1d) begin
         return 8'hff;
      end
      if (ch == 5'h1e) begin
         return 8'h00;
      end
      return 8'h13 + {ch[2:0], 5'h00} + ofs;
   endfunction

   task automatic bus(input logic we, input logic [7:0] adr,
                      input logic [7:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                  dat: {24'h000000, wd}};
      @(posedge clk_sys);
      while (wb_rsp.ack !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 20) begin
         cmp(32'h0, 32'h1);
      end
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [31:0] unused;
      bus(1'b1, adr, wd, unused);
   endtask

   task automatic rd_cmp(input logic [7:0] adr, input logic [7:0] exp);
      bus(1'b0, adr, 8'h00, rdat);
      cmp(rdat, {24'h000000, exp});
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      while (irq_request !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[7] !== 1'b1 && n < 400) begin
         bus(1'b0, 8'h00, 8'h00, rdat);
         n++;
      end
      cmp({31'h0, rdat[7]}, 32'h1);
   endtask

   task automatic t_reset();
      rd_cmp(8'h00, 8'h1f);
      rd_cmp(8'h04, 8'h00);
      rd_cmp(8'h08, 8'h00);
      rd_cmp(8'h0c, 8'h00);
      cmp({31'h0, analog.power_down}, 32'h1);
      wr(8'h08, 8'hff);
      rd_cmp(8'h08, 8'hf0);
      wr(8'h08, 8'h10);
   endtask

   task automatic t_channels();
      logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                 5'h06, 5'h07, 5'h1d, 5'h1e};
      foreach (codes[i]) begin
         wr(8'h00, {3'h0, codes[i]});
         wait_done();
         rd_cmp(8'h04, expv(codes[i], 8'h00));
         rd_cmp(8'h00, {3'h0, codes[i]});
      end
      repeat (60) @(posedge clk_sys);
      rd_cmp(8'h00, 8'h1e);
      wr(8'h00, 8'h08);
      wait_done();
      bus(1'b0, 8'h04, 8'h00, rdat);
   endtask

   task automatic t_irq();
      int n;
      wr(8'h00, 8'h42);
      wait_irq(n);
      cmp({31'h0, irq_request}, 32'h1);
      rd_cmp(8'h00, 8'h42);
      rd_cmp(8'h04, expv(5'h02, 8'h00));
      cmp({31'h0, irq_request}, 32'h0);
      wr(8'h00, 8'h42);
      wait_irq(n);
      wr(8'h00, 8'h02);
      cmp({31'h0, irq_request}, 32'h0);
      wait_done();
      rd_cmp(8'h04, expv(5'h02, 8'h00));
   endtask

   task automatic t_prescale();
      logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0, 8'h00};
      int ratio [7] = '{1, 2, 4, 8, 16, 16, 4};
      int n;
      foreach (cfg[i]) begin
         wr(8'h08, cfg[i]);
         wr(8'h00, 8'h41);
         wait_irq(n);
         cmp({31'h0, n >= 16 * ratio[i] - 3 && n <= 17 * ratio[i] + 3},
             32'h1);
         bus(1'b0, 8'h04, 8'h00, rdat);
      end
      wr(8'h08, 8'h10);
   endtask

   task automatic t_continuous();
      offset <= 8'h05;
      wr(8'h00, 8'h24);
      wait_done();
      offset <= 8'h20;
      repeat (100) @(posedge clk_sys);
      rd_cmp(8'h04, expv(5'h04, 8'h20));
      wait_done();
      wr(8'h00, 8'h04);
      bus(1'b0, 8'h04, 8'h00, rdat);
      wait_done();
      offset <= 8'h00;
      bus(1'b0, 8'h04, 8'h00, rdat);
      repeat (60) @(posedge clk_sys);
      rd_cmp(8'h00, 8'h04);
   endtask

   task automatic t_abort();
      int n;
      wr(8'h00, 8'h01);
      repeat (6) @(posedge clk_sys);
      wr(8'h00, 8'h06);
      wait_done();
      rd_cmp(8'h04, expv(5'h06, 8'h00));
      wr(8'h00, 8'h05);
      repeat (5) @(posedge clk_sys);
      stop_mode <= 1'b1;
      repeat (40) @(posedge clk_sys);
      cmp({31'h0, analog.power_down}, 32'h1);
      rd_cmp(8'h00, 8'h05);
      stop_mode <= 1'b0;
      wait_done();
      rd_cmp(8'h04, expv(5'h05, 8'h00));
      wr(8'h00, 8'h1f);
      repeat (60) @(posedge clk_sys);
      rd_cmp(8'h00, 8'h1f);
      cmp({31'h0, analog.power_down}, 32'h1);
      wr(8'h00, 8'h47);
      wait_irq(n);
      cmp({31'h0, n >= 30 && n < 80}, 32'h1);
      rd_cmp(8'h04, expv(5'h07, 8'h00));
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      checks = 0;
      arst_n = 1'b0;
      wb_req = '0;
      stop_mode = 1'b0;
      offset = 8'h00;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_channels();
      t_irq();
      t_prescale();
      t_continuous();
      t_abort();
      conclude();
   end
endmodule
